// [design/cbc_pkg.sv]
// constants used by the processor end and the bench; the system logic end uses none of them
// assumes one clock core_clk at 10 MHz, reset rst_b async active low
// Overview of operation
// (RULE1) hold acked one edge after last ready
// (RULE2) idle bus: hold acked next edge
// (RULE3) hold honoured during init and reset; while rst_b is low hold_acknowledge is held at 0
// (RULE4) drop ack after hold drops; float bus
// (RULE5) error bit zero, ignore asserted: continue
// (RULE6) error bit zero, ignore negated: stall
// (RULE7) error bit one: raise vector 10h
// (RULE8) insensitive target: ignore exception, continue
// (RULE9) ignore input level, async two clocks
// (RULE10) init: flush, restart at reset vector
// (RULE11) init keeps caches, fp, msr, control bits
// (RULE12) init latched on rise, act at boundary
// (RULE13) init three edges before io ready
// (RULE14) async init low two, high two
// (RULE15) interrupt only if flag set, two acks
// (RULE16) interrupt level sampled, act at boundary
// (RULE17) hold interrupt until ack sequence done
// (RULE18) snoop hit: invalid or shared, writeback first
// (RULE19) invalidate sampled only with address strobe
// (RULE20) cacheable fill: 32-byte burst, four readies
// (RULE21) non-cacheable or page uncached: single, uncached
// (RULE22) cache enable sampled first ready only; the code samples it on the first ready or next-address of the cycle
// (RULE23) same cache enable on backoff restart
package cbc_pkg;
  localparam logic [31:0] cbc_reset_vector = 32'h0FFF_FFF0;
  localparam logic [7:0] cbc_fp_vector = 8'h10;
  localparam logic [2:0] cbc_burst_beats = 3'h4;
  localparam logic [2:0] cbc_single_beats = 3'h1;
  localparam logic [1:0] cbc_intack_cycles = 2'h2;
  localparam logic [1:0] cbc_init_lead_edges = 2'h3;
  localparam logic [1:0] cbc_async_min_clocks = 2'h2;
  // cache line states
  localparam logic [1:0] cbc_line_invalid = 2'h0;
  localparam logic [1:0] cbc_line_shared = 2'h1;
  localparam logic [1:0] cbc_line_exclusive = 2'h2;
  localparam logic [1:0] cbc_line_modified = 2'h3;
endpackage

// [design/cbc_if.sv]
// control input pins between processor and system logic
// assumes both ends share core_clk
interface cbc_if;
  logic hold;
  logic hold_acknowledge;
  logic bus_float;
  logic burst_ready_n;
  logic next_address_n;
  logic backoff_n;
  logic ignore_fp_error_n;
  logic init;
  logic maskable_interrupt;
  logic intack_cycle;
  logic [7:0] intack_vector;
  logic external_address_strobe_n;
  logic snoop_invalidate_request;
  logic cache_enable_n;
  logic cache_intent_n;
  logic page_cache_disable_out;
  logic cycle_start;
  logic cycle_is_read;
  logic cycle_is_writeback;
  modport cpu (
    input hold, burst_ready_n, next_address_n, backoff_n, ignore_fp_error_n, init,
    input maskable_interrupt, intack_vector, external_address_strobe_n,
    input snoop_invalidate_request, cache_enable_n,
    output hold_acknowledge, bus_float, intack_cycle, cache_intent_n,
    output page_cache_disable_out, cycle_start, cycle_is_read, cycle_is_writeback
  );
  modport sys (
    output hold, burst_ready_n, next_address_n, backoff_n, ignore_fp_error_n, init,
    output maskable_interrupt, intack_vector, external_address_strobe_n,
    output snoop_invalidate_request, cache_enable_n,
    input hold_acknowledge, bus_float, intack_cycle, cache_intent_n,
    input page_cache_disable_out, cycle_start, cycle_is_read, cycle_is_writeback
  );
endinterface

// [design/cbc_cpu.sv]
// processor end: hold, fp error, init, interrupt, snoop and cache enable
// assumes system logic end on same core_clk via cbc_if.cpu
//
// The address map and the address-and-strobe port were decided locally.
module cbc_cpu (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // link
  cbc_if.cpu bus,
  // core side requests
  input wire logic start_read,
  input wire logic start_write,
  input wire logic fill_intent,
  input wire logic page_uncached,
  input wire logic boundary,
  input wire logic fp_pending,
  input wire logic target_sensitive,
  input wire logic numeric_error_bit,
  input wire logic interrupt_flag,
  input wire logic system_management_irq_n,
  input wire logic nmi,
  input wire logic snoop_hit,
  input wire logic snoop_modified,
  // core side status
  output logic stalled,
  output logic continue_exec,
  output logic [7:0] vector_out,
  output logic vector_valid,
  output logic init_taken,
  output logic [31:0] fetch_address,
  output logic line_cached,
  output logic [1:0] snoop_new_state,
  output logic snoop_writeback,
  output logic snoop_done
);
  typedef enum logic [3:0] {
    cbc_idle_type = 4'h1,
    cbc_run_type = 4'h2,
    cbc_held_type = 4'h4,
    cbc_ack_type = 4'h8
  } cbc_state_type;

  // ==========================================================
  // input synchronisers for async-capable pins
  logic ign_meta_reg, ign_reg, irq_meta_reg, irq_reg, init_meta_reg, init_reg;
  logic init_prev_reg, init_pend_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ign_meta_reg <= 1'b1;
      ign_reg <= 1'b1;
      irq_meta_reg <= 1'b0;
      irq_reg <= 1'b0;
      init_meta_reg <= 1'b0;
      init_reg <= 1'b0;
    end else begin
      ign_meta_reg <= bus.ignore_fp_error_n; // RULE9
      ign_reg <= ign_meta_reg;
      irq_meta_reg <= bus.maskable_interrupt; // RULE16
      irq_reg <= irq_meta_reg;
      init_meta_reg <= bus.init;
      init_reg <= init_meta_reg;
    end
  end

  // ==========================================================
  // bus cycle and hold
  cbc_state_type state_reg;
  logic [2:0] beats_reg;
  logic sampled_reg, fill_reg, read_reg, wb_reg, nocache_reg;
  logic first_beat;
  logic fill_now;
  logic last_beat;
  assign first_beat = !sampled_reg && (!bus.burst_ready_n || !bus.next_address_n);
  // line fill decided on the first ready or next-address of a read
  assign fill_now = first_beat && read_reg && !wb_reg && !bus.cache_intent_n
                    && !bus.cache_enable_n && !nocache_reg;
  assign last_beat = !bus.burst_ready_n && !fill_now
                     && beats_reg == cbc_pkg::cbc_single_beats;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= cbc_idle_type;
      beats_reg <= 3'h0;
      bus.hold_acknowledge <= 1'b0;
      bus.bus_float <= 1'b0;
    end else begin
      unique case (state_reg)
        cbc_idle_type: begin
          if (bus.hold) begin
            state_reg <= cbc_held_type; // RULE2 RULE3
            bus.hold_acknowledge <= 1'b1;
            bus.bus_float <= 1'b1; // RULE4
          end else if (bus.intack_cycle || start_read || start_write) begin
            state_reg <= cbc_run_type;
            beats_reg <= cbc_pkg::cbc_single_beats;
          end
        end
        cbc_run_type: begin
          if (!bus.backoff_n) begin
            state_reg <= cbc_idle_type;
          end else if (last_beat) begin
            if (bus.hold) begin
              state_reg <= cbc_held_type; // RULE1
              bus.hold_acknowledge <= 1'b1;
              bus.bus_float <= 1'b1;
            end else begin
              state_reg <= cbc_idle_type;
            end
          end else if (fill_now && !bus.burst_ready_n) begin
            beats_reg <= cbc_pkg::cbc_burst_beats - 3'h1; // RULE20
          end else if (fill_now) begin
            beats_reg <= cbc_pkg::cbc_burst_beats; // RULE20
          end else if (!bus.burst_ready_n) begin
            beats_reg <= beats_reg - 3'h1;
          end
        end
        cbc_held_type: begin
          if (!bus.hold) begin
            state_reg <= cbc_idle_type; // RULE4
            bus.hold_acknowledge <= 1'b0;
            bus.bus_float <= 1'b0;
          end
        end
        default: state_reg <= cbc_idle_type;
      endcase
    end
  end

  // cycle attributes and cache enable capture
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sampled_reg <= 1'b0;
      fill_reg <= 1'b0;
      read_reg <= 1'b0;
      wb_reg <= 1'b0;
      nocache_reg <= 1'b0;
      line_cached <= 1'b0;
      bus.cycle_start <= 1'b0;
      bus.cycle_is_read <= 1'b0;
      bus.cycle_is_writeback <= 1'b0;
      bus.cache_intent_n <= 1'b1;
      bus.page_cache_disable_out <= 1'b0;
    end else begin
      bus.cycle_start <= 1'b0;
      line_cached <= 1'b0;
      if (state_reg == cbc_idle_type && !bus.hold && !bus.intack_cycle
          && (start_read || start_write)) begin
        bus.cycle_start <= 1'b1;
        read_reg <= start_read;
        wb_reg <= start_write && fill_intent;
        nocache_reg <= page_uncached;
        sampled_reg <= 1'b0;
        fill_reg <= 1'b0;
        bus.cycle_is_read <= start_read;
        bus.cycle_is_writeback <= start_write && fill_intent;
        bus.cache_intent_n <= !fill_intent;
        bus.page_cache_disable_out <= page_uncached;
      end else if (state_reg == cbc_run_type && first_beat && bus.backoff_n) begin
        sampled_reg <= 1'b1; // RULE22
        fill_reg <= fill_now; // RULE21
      end else if (state_reg == cbc_run_type && last_beat && bus.backoff_n) begin
        line_cached <= fill_reg;
        fill_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // floating-point error, interrupt and init at boundaries
  logic [1:0] intack_cnt_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      init_prev_reg <= 1'b0;
      init_pend_reg <= 1'b0;
      stalled <= 1'b0;
      continue_exec <= 1'b0;
      vector_out <= 8'h00;
      vector_valid <= 1'b0;
      init_taken <= 1'b0;
      fetch_address <= cbc_pkg::cbc_reset_vector;
      intack_cnt_reg <= 2'h0;
      bus.intack_cycle <= 1'b0;
    end else begin
      init_prev_reg <= init_reg;
      continue_exec <= 1'b0;
      vector_valid <= 1'b0;
      init_taken <= 1'b0;
      if (init_reg && !init_prev_reg)
        init_pend_reg <= 1'b1; // RULE12
      if (intack_cnt_reg != 2'h0) begin
        if (state_reg == cbc_run_type && !bus.burst_ready_n) begin
          if (intack_cnt_reg == cbc_pkg::cbc_intack_cycles) begin
            bus.intack_cycle <= 1'b0;
            vector_out <= bus.intack_vector; // RULE15
            vector_valid <= 1'b1;
            intack_cnt_reg <= 2'h0;
          end else begin
            intack_cnt_reg <= intack_cnt_reg + 2'h1;
          end
        end else if (state_reg == cbc_idle_type && !bus.hold && !bus.intack_cycle
            && intack_cnt_reg < cbc_pkg::cbc_intack_cycles)
          bus.intack_cycle <= 1'b1;
      end else if (boundary || stalled) begin
        if (init_pend_reg) begin
          // a new rising edge in this cycle stays pending
          init_pend_reg <= init_reg && !init_prev_reg; // RULE10 RULE11
          init_taken <= 1'b1;
          stalled <= 1'b0;
          fetch_address <= cbc_pkg::cbc_reset_vector;
        end else if (irq_reg && interrupt_flag) begin
          stalled <= 1'b0; // RULE15 RULE6
          intack_cnt_reg <= 2'h1;
          bus.intack_cycle <= 1'b1;
        end else if (stalled && (!nmi && system_management_irq_n)) begin
          if (!ign_reg) begin
            stalled <= 1'b0; // RULE6
            continue_exec <= 1'b1;
          end
        end else if (stalled) begin
          stalled <= 1'b0; // RULE6
        end else if (fp_pending && target_sensitive && numeric_error_bit) begin
          vector_out <= cbc_pkg::cbc_fp_vector; // RULE7
          vector_valid <= 1'b1;
        end else if (fp_pending && target_sensitive && ign_reg) begin
          stalled <= 1'b1; // RULE6
        end else begin
          continue_exec <= 1'b1; // RULE5 RULE8
        end
      end
    end
  end

  // ==========================================================
  // snoop response
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      snoop_new_state <= cbc_pkg::cbc_line_invalid;
      snoop_writeback <= 1'b0;
      snoop_done <= 1'b0;
    end else begin
      snoop_done <= 1'b0;
      snoop_writeback <= 1'b0;
      if (!bus.external_address_strobe_n && snoop_hit) begin
        snoop_done <= 1'b1; // RULE19
        snoop_writeback <= snoop_modified; // RULE18
        snoop_new_state <= bus.snoop_invalidate_request ? cbc_pkg::cbc_line_invalid
                                                        : cbc_pkg::cbc_line_shared;
      end
    end
  end
endmodule

// [design/cbc_sys.sv]
// system logic end: drives control inputs from user requests
// assumes processor end on same core_clk via cbc_if.sys
module cbc_sys (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // link
  cbc_if.sys bus,
  // user side
  input wire logic want_bus,
  input wire logic ready_beat,
  input wire logic next_addr,
  input wire logic do_backoff,
  input wire logic ignore_error,
  input wire logic raise_init,
  input wire logic raise_interrupt,
  input wire logic [7:0] interrupt_number,
  input wire logic snoop_req,
  input wire logic snoop_invalidate,
  input wire logic cacheable,
  // status
  output logic bus_granted,
  output logic interrupt_served
);
  logic level_held_reg, repeat_reg, intack_prev_reg;
  // ==========================================================
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.hold <= 1'b0;
      bus.burst_ready_n <= 1'b1;
      bus.next_address_n <= 1'b1;
      bus.backoff_n <= 1'b1;
      bus.ignore_fp_error_n <= 1'b1;
      bus.init <= 1'b0;
      bus.external_address_strobe_n <= 1'b1;
      bus.snoop_invalidate_request <= 1'b0;
      bus_granted <= 1'b0;
    end else begin
      bus.hold <= want_bus;
      bus_granted <= bus.hold_acknowledge;
      bus.burst_ready_n <= !ready_beat;
      bus.next_address_n <= !next_addr;
      bus.backoff_n <= !do_backoff;
      bus.ignore_fp_error_n <= !ignore_error; // RULE9
      bus.init <= raise_init; // RULE13 RULE14
      bus.external_address_strobe_n <= !(snoop_req && bus.hold_acknowledge);
      bus.snoop_invalidate_request <= snoop_invalidate;
    end
  end

  // cache enable, repeated after backoff
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.cache_enable_n <= 1'b1;
      level_held_reg <= 1'b0;
      repeat_reg <= 1'b0;
    end else begin
      if (bus.cycle_start && !repeat_reg)
        level_held_reg <= cacheable;
      // aborted cycle sees the same level on its restart
      if (!bus.backoff_n)
        repeat_reg <= 1'b1;
      else if (!bus.burst_ready_n || (bus.cycle_start && !bus.cycle_is_read))
        repeat_reg <= 1'b0;
      bus.cache_enable_n <= repeat_reg ? !level_held_reg : !cacheable; // RULE23
    end
  end

  // interrupt held until acknowledge done
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.maskable_interrupt <= 1'b0;
      bus.intack_vector <= 8'h00;
      intack_prev_reg <= 1'b0;
      interrupt_served <= 1'b0;
    end else begin
      intack_prev_reg <= bus.intack_cycle;
      interrupt_served <= 1'b0;
      bus.intack_vector <= interrupt_number;
      if (raise_interrupt)
        bus.maskable_interrupt <= 1'b1;
      else if (intack_prev_reg && !bus.intack_cycle) begin
        bus.maskable_interrupt <= 1'b0; // RULE17
        interrupt_served <= 1'b1;
      end
    end
  end
endmodule

// [test/cbc_assertions.sv]
// checks on the hold handshake across the link
// assumes link pins sampled on core_clk, rst_b async active low
module cbc_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // link pins
  input wire logic hold,
  input wire logic hold_acknowledge,
  input wire logic bus_float,
  input wire logic burst_ready_n,
  input wire logic backoff_n,
  input wire logic init,
  input wire logic intack_cycle,
  input wire logic cache_enable_n,
  input wire logic cache_intent_n,
  input wire logic page_cache_disable_out,
  input wire logic cycle_start,
  input wire logic cycle_is_read
);
  // ======
  // beats left in the running cycle
  logic [2:0] left_reg;
  logic first_reg;
  logic fill;
  logic last_beat;
  logic busy;
  assign fill = cycle_is_read && !cache_intent_n && !page_cache_disable_out && !cache_enable_n;
  assign last_beat = !burst_ready_n && left_reg == 3'h1 && !(first_reg && fill);
  assign busy = left_reg != 3'h0 || cycle_start || intack_cycle;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      left_reg <= 3'h0;
      first_reg <= 1'h0;
    end else if (!backoff_n) begin
      left_reg <= 3'h0;
      first_reg <= 1'h0;
    end else if (cycle_start) begin
      left_reg <= 3'h1;
      first_reg <= 1'h1;
    end else if (!burst_ready_n && left_reg != 3'h0) begin
      left_reg <= (first_reg && fill) ? 3'h3 : left_reg - 3'h1;
      first_reg <= 1'h0;
    end
  end
  // ======
  // properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence idle_hold_s;
    hold && !busy;
  endsequence
  sequence last_ready_s;
    hold && last_beat;
  endsequence
  hold_idle_a: assert property (idle_hold_s |=> hold_acknowledge)
    else $error("idle hold not acknowledged");
  hold_last_a: assert property (last_ready_s |=> hold_acknowledge)
    else $error("no acknowledge after last ready");
  init_hold_a: assert property ((idle_hold_s and init) |=> hold_acknowledge)
    else $error("hold ignored during init");
  ack_cause_a: assert property ($rose(hold_acknowledge) |->
    $past(hold) && ($past(last_beat) || !$past(busy)))
    else $error("acknowledge without cause");
  ack_drop_a: assert property (hold_acknowledge && !hold |=> !hold_acknowledge)
    else $error("acknowledge kept after hold dropped");
  ack_stands_a: assert property (hold_acknowledge && hold |=> hold_acknowledge)
    else $error("acknowledge dropped early");
  float_ack_a: assert property (hold_acknowledge |-> bus_float)
    else $error("bus driven while acknowledged");
  no_cycle_a: assert property (hold_acknowledge |-> !cycle_start)
    else $error("cycle started while acknowledged");
endmodule

// [test/tb_top.sv]
// bench: processor end and system logic end joined by cbc_if
// assumes cbc_pkg, cbc_if, cbc_cpu, cbc_sys, cbc_assertions compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ======
  // stimulus and status
  logic core_clk = 1'h0;
  logic rst_b = 1'h0;
  logic start_read = 1'h0, start_write = 1'h0, fill_intent = 1'h0, page_uncached = 1'h0;
  logic boundary = 1'h0, fp_pending = 1'h0, target_sensitive = 1'h0, numeric_error_bit = 1'h0;
  logic interrupt_flag = 1'h0, system_management_irq_n = 1'h1, nmi = 1'h0;
  logic snoop_hit = 1'h0, snoop_modified = 1'h0, snoop_req = 1'h0, snoop_invalidate = 1'h0;
  logic want_bus = 1'h0, ready_beat = 1'h0, next_addr = 1'h0, do_backoff = 1'h0;
  logic ignore_error = 1'h0, raise_init = 1'h0, raise_interrupt = 1'h0, cacheable = 1'h0;
  logic [7:0] interrupt_number = 8'h00;
  logic stalled, continue_exec, vector_valid, init_taken, line_cached;
  logic snoop_writeback, snoop_done, bus_granted, interrupt_served;
  logic [7:0] vector_out;
  logic [31:0] fetch_address;
  logic [1:0] snoop_new_state;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  logic clr = 1'h0;
  logic [6:0] seen = 7'h00;
  logic [7:0] vec_cap = 8'h00;
  logic [1:0] state_cap = 2'h0;
  // write, fill intent, page uncached, cacheable, cached
  logic [4:0] rd_tab [5] = '{5'h0B, 5'h0E, 5'h08, 5'h02, 5'h1A};
  // sensitive, numeric error, ignore, vector
  logic [3:0] fp_tab [3] = '{4'h4, 4'hA, 4'hF};
  always #50 core_clk = ~core_clk;
  // ======
  // design
  cbc_if cbc_if_i ();
  cbc_cpu cbc_cpu_i (.core_clk, .rst_b, .bus(cbc_if_i.cpu), .start_read, .start_write,
    .fill_intent, .page_uncached, .boundary, .fp_pending, .target_sensitive,
    .numeric_error_bit, .interrupt_flag, .system_management_irq_n, .nmi, .snoop_hit,
    .snoop_modified, .stalled, .continue_exec, .vector_out, .vector_valid, .init_taken,
    .fetch_address, .line_cached, .snoop_new_state, .snoop_writeback, .snoop_done);
  cbc_sys cbc_sys_i (.core_clk, .rst_b, .bus(cbc_if_i.sys), .want_bus, .ready_beat,
    .next_addr, .do_backoff, .ignore_error, .raise_init, .raise_interrupt,
    .interrupt_number, .snoop_req, .snoop_invalidate, .cacheable, .bus_granted,
    .interrupt_served);
  cbc_assertions cbc_assertions_i (.core_clk, .rst_b, .hold(cbc_if_i.hold),
    .hold_acknowledge(cbc_if_i.hold_acknowledge), .bus_float(cbc_if_i.bus_float),
    .burst_ready_n(cbc_if_i.burst_ready_n), .backoff_n(cbc_if_i.backoff_n),
    .init(cbc_if_i.init), .intack_cycle(cbc_if_i.intack_cycle),
    .cache_enable_n(cbc_if_i.cache_enable_n), .cache_intent_n(cbc_if_i.cache_intent_n),
    .page_cache_disable_out(cbc_if_i.page_cache_disable_out),
    .cycle_start(cbc_if_i.cycle_start), .cycle_is_read(cbc_if_i.cycle_is_read));
  // ======
  // sticky capture of status pulses
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    seen <= clr ? 7'h00 : seen | {interrupt_served, snoop_writeback, snoop_done,
      line_cached, init_taken, vector_valid, continue_exec};
    if (clr) vec_cap <= 8'h00;
    else if (vector_valid) vec_cap <= vector_out;
    if (snoop_done) state_cap <= snoop_new_state;
    if (cycles == 4000) begin
      fails++;
      final_report();
    end
  end
  // ======
  // tasks
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // 0 granted, 1 cycle start, from 2 on the sticky pulses
  function automatic logic pick(input int w);
    if (w == 0) return bus_granted;
    if (w == 1) return cbc_if_i.cycle_start;
    return seen[w - 2];
  endfunction
  task automatic wait_for(input int w);
    int n;
    n = 0;
    while (pick(w) !== 1'h1 && n < 40) begin
      tick(1);
      n++;
    end
  endtask
  task automatic clear();
    clr <= 1'h1;
    tick(1);
    clr <= 1'h0;
  endtask
  task automatic kick();
    clear();
    boundary <= 1'h1;
    tick(1);
    boundary <= 1'h0;
  endtask
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ======
  // tests
  initial begin
    tick(5);
    rst_b <= 1'h1;
    tick(2);
    clear();
    raise_init <= 1'h1;
    want_bus <= 1'h1;
    wait_for(0);
    chk("hold ack", 1, cbc_if_i.hold_acknowledge);
    chk("bus float", 1, cbc_if_i.bus_float);
    chk("early init", 0, seen[2]);
    want_bus <= 1'h0;
    raise_init <= 1'h0;
    tick(4);
    chk("ack drop", 0, cbc_if_i.hold_acknowledge);
    kick();
    wait_for(4);
    chk("init taken", 1, seen[2]);
    chk("fetch address", cbc_pkg::cbc_reset_vector, fetch_address);
    $display("test hold and init done");
    for (int i = 0; i < 5; i++) begin
      fill_intent <= rd_tab[i][3];
      page_uncached <= rd_tab[i][2];
      cacheable <= rd_tab[i][1];
      clear();
      start_write <= rd_tab[i][4];
      start_read <= !rd_tab[i][4];
      tick(1);
      start_write <= 1'h0;
      start_read <= 1'h0;
      wait_for(1);
      chk("writeback flag", rd_tab[i][4] & rd_tab[i][3], cbc_if_i.cycle_is_writeback);
      want_bus <= (i == 0);
      ready_beat <= 1'h1;
      tick(rd_tab[i][0] ? 4 : 1);
      ready_beat <= 1'h0;
      tick(4);
      chk("line cached", rd_tab[i][0], seen[3]);
      chk("granted after cycle", i == 0, bus_granted);
      want_bus <= 1'h0;
      tick(4);
    end
    $display("test cycles done");
    fill_intent <= 1'h1;
    page_uncached <= 1'h0;
    cacheable <= 1'h1;
    for (int r = 0; r < 2; r++) begin
      clear();
      start_read <= 1'h1;
      tick(1);
      start_read <= 1'h0;
      wait_for(1);
      do_backoff <= (r == 0);
      cacheable <= 1'h0;
      ready_beat <= (r == 1);
      tick(r == 1 ? 4 : 1);
      do_backoff <= 1'h0;
      ready_beat <= 1'h0;
      tick(4);
    end
    chk("restart cached", 1, seen[3]);
    $display("test backoff done");
    for (int i = 0; i < 3; i++) begin
      target_sensitive <= fp_tab[i][3];
      numeric_error_bit <= fp_tab[i][2];
      ignore_error <= fp_tab[i][1];
      fp_pending <= 1'h1;
      tick(5);
      kick();
      wait_for(fp_tab[i][0] ? 3 : 2);
      chk("fp continue", !fp_tab[i][0], seen[0]);
      chk("fp vector", fp_tab[i][0] ? cbc_pkg::cbc_fp_vector : 8'h00, vec_cap);
      fp_pending <= 1'h0;
      tick(2);
    end
    ignore_error <= 1'h0;
    numeric_error_bit <= 1'h0;
    fp_pending <= 1'h1;
    tick(5);
    kick();
    tick(4);
    chk("stall", 1, stalled);
    chk("no continue", 0, seen[0]);
    ignore_error <= 1'h1;
    wait_for(2);
    chk("resume", 0, stalled);
    fp_pending <= 1'h0;
    ignore_error <= 1'h0;
    tick(5);
    $display("test fp error done");
    interrupt_number <= 8'h5A;
    raise_interrupt <= 1'h1;
    tick(1);
    raise_interrupt <= 1'h0;
    tick(4);
    kick();
    tick(10);
    chk("masked interrupt", 0, vec_cap);
    interrupt_flag <= 1'h1;
    ready_beat <= 1'h1;
    kick();
    wait_for(3);
    tick(3);
    chk("interrupt vector", 8'h5A, vec_cap);
    chk("interrupt served", 1, seen[6]);
    chk("interrupt dropped", 0, cbc_if_i.maskable_interrupt);
    tick(3);
    $display("test interrupt done");
    want_bus <= 1'h1;
    wait_for(0);
    for (int i = 0; i < 4; i++) begin
      snoop_hit <= 1'h1;
      snoop_modified <= i[0];
      snoop_invalidate <= i[1];
      clear();
      snoop_req <= 1'h1;
      tick(1);
      snoop_req <= 1'h0;
      snoop_invalidate <= !i[1];
      wait_for(6);
      tick(2);
      chk("line state", i[1] ? cbc_pkg::cbc_line_invalid : cbc_pkg::cbc_line_shared,
        state_cap);
      chk("writeback", i[0], seen[5]);
    end
    ready_beat <= 1'h0;
    want_bus <= 1'h0;
    $display("test snoop done");
    final_report();
  end
endmodule
